// >>> sbm_pkg.sv
// Package with constants and carrier types for the system bus master interface.
package sbm_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_NS        = 100;
   localparam int TIMEOUT_US    = 15;
   localparam int TIMEOUT_CYC   = (TIMEOUT_US * 1000) / CLK_NS;
   localparam int TO_W          = 8;
   localparam int BCLK_DIV      = 1;
   localparam int CCLK_DIV      = 1;
   localparam int INIT_HOLD_CYC = 16;
   // -----------------------------------------------------------------
   // Widths and cycle kinds
   // -----------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int AREQ_W = 24;

   typedef enum logic [1:0] {
      SP_LOCAL = 2'b00,
      SP_MEM   = 2'b01,
      SP_IO    = 2'b10,
      SP_NONE  = 2'b11
   } space_e;

   typedef struct packed {
      logic [AREQ_W-1:0] addr;
      space_e            space;
      logic              write;
      logic [DATA_W-1:0] wdata;
   } cpu_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] adr;
      logic [DATA_W-1:0] dat;
      logic              mrd;
      logic              mwr;
      logic              iord;
      logic              iowr;
   } sbus_cmd_s;
endpackage

// >>> sbm_timeout.sv
// Cycle timeout counter that fires once when a system bus cycle hangs.
`timescale 1ns/100ps
module sbm_timeout #(
   parameter int LIMIT = sbm_pkg::TIMEOUT_CYC
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output logic      expired_o
);
   localparam int W = sbm_pkg::TO_W;
   logic [W-1:0] count;

   // Counting restarts whenever the watched cycle is not in progress.
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run_i) begin
         count     <= '0;
         expired_o <= 1'b0;
      end else if (count == W'(LIMIT - 1)) begin
         expired_o <= 1'b1;
      end else begin
         count     <= count + 1'b1;
         expired_o <= 1'b0;
      end
   end
endmodule

// >>> sbm_master.sv
// System bus master interface: arbitration, cycle control, timeout and bus services.
// Functional notes
// - A system bus cycle with no acknowledge within 15 us is aborted so the processor continues and the bus frees.
// - An off-board cycle requests the bus automatically and yields to any higher priority master.
// - Arbitration works in a serial chain of up to three masters or with a parallel resolver of up to sixteen.
// - Twenty address lines reach one megabyte of memory and a separate megabyte of I/O space.
// - Optionally the block drives the bus clock, constant clock and initialize for the whole bus.
// - The processor can assert initialize by program in addition to the power-fail source.
// - Local memory accesses finish internally without requesting or holding the system bus.
// - The block never answers system bus cycles; on-board memory is private.
`timescale 1ns/100ps
module sbm_master (
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   input  wire logic              cpu_req_i,
   input  wire sbm_pkg::cpu_req_s cpu_cmd_i,
   output logic                   cpu_ack_o,
   output logic                   cpu_err_o,
   output logic [15:0]            cpu_rdata_o,
   output logic                   local_sel_o,
   input  wire logic              local_ack_i,
   input  wire logic [15:0]       local_rdata_i,
   input  wire logic              clk_master_i,
   input  wire logic              init_prog_i,
   input  wire logic              power_fail_i,
   input  wire logic              bprn_n_i,
   output logic                   bpro_n_o,
   output logic                   breq_n_o,
   input  wire logic              busy_n_i,
   output logic                   busy_n_o,
   output logic                   busy_n_oe_o,
   output sbm_pkg::sbus_cmd_s     bus_o,
   output logic                   bus_oe_o,
   input  wire logic [15:0]       bus_dat_i,
   input  wire logic              xack_n_i,
   output logic                   bclk_n_o,
   output logic                   cclk_n_o,
   output logic                   init_n_o,
   output logic                   init_n_oe_o
);
   // -----------------------------------------------------------------
   // Cycle state machine
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_REQ   = 3'b001,
      ST_CMD   = 3'b011,
      ST_DONE  = 3'b010,
      ST_LOCAL = 3'b110
   } state_e;

   state_e state;
   logic   timed_out;
   logic   bus_owned;
   logic   bclk_en;
   logic [7:0] init_cnt;

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------
   // True for cycles that must leave the board over the system bus.
   function automatic logic is_offboard(input sbm_pkg::space_e sp);
      return (sp == sbm_pkg::SP_MEM) || (sp == sbm_pkg::SP_IO);
   endfunction

   // True while a remote cycle holds its bus request, from arbitration to the end of the command.
   function automatic logic is_remote(input state_e st);
      return (st == ST_REQ) || (st == ST_CMD);
   endfunction

   // Command strobes in the order mrd, mwr, iord, iowr; all stay low unless the bus is owned,
   // so a slave can never see a strobe from a board that has lost or given up the bus.
   function automatic logic [3:0] strobes(input logic owned, input sbm_pkg::space_e sp, input logic wr);
      logic [3:0] s;
      s = 4'h0;
      if (owned && sp == sbm_pkg::SP_MEM) begin
         s = wr ? 4'b0100 : 4'b1000;
      end else if (owned && sp == sbm_pkg::SP_IO) begin
         s = wr ? 4'b0001 : 4'b0010;
      end
      return s;
   endfunction

   // -----------------------------------------------------------------
   // Timeout
   // -----------------------------------------------------------------
   // The counter also runs during arbitration, so a bus hogged by another master aborts too.
   sbm_timeout #(
      .LIMIT(sbm_pkg::TIMEOUT_CYC)
   ) u_timeout (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .run_i    (is_remote(state)),
      .expired_o(timed_out)
   );

   // Main sequencer: local cycles never touch the bus; remote ones arbitrate first.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cpu_req_i && cpu_cmd_i.space == sbm_pkg::SP_LOCAL) begin
                  state <= ST_LOCAL;
               end else if (cpu_req_i && is_offboard(cpu_cmd_i.space)) begin
                  state <= ST_REQ;
               end else if (cpu_req_i) begin
                  state <= ST_DONE;
               end
            end
            ST_LOCAL: begin
               if (local_ack_i) begin
                  state <= ST_DONE;
               end
            end
            ST_REQ: begin
               // Grant only on a bus clock phase with priority in and the bus free.
               if (timed_out) begin
                  state <= ST_DONE;
               end else if (bclk_en && !bprn_n_i && busy_n_i) begin
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (timed_out || !xack_n_i) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (!cpu_req_i) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Processor answer
   // -----------------------------------------------------------------
   // Data and ack, or an error on timeout or non-existent space; both are one-cycle pulses
   // so the processor may drop its request at once without a second answer following.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cpu_ack_o   <= 1'b0;
         cpu_err_o   <= 1'b0;
         cpu_rdata_o <= 16'h0000;
      end else begin
         cpu_ack_o <= 1'b0;
         cpu_err_o <= 1'b0;
         if (state == ST_LOCAL && local_ack_i) begin
            cpu_ack_o   <= 1'b1;
            cpu_rdata_o <= local_rdata_i;
         end else if (state == ST_CMD && !xack_n_i && !timed_out) begin
            cpu_ack_o   <= 1'b1;
            cpu_rdata_o <= bus_dat_i;
         end else if ((state == ST_CMD || state == ST_REQ) && timed_out) begin
            cpu_err_o <= 1'b1;
         end else if (state == ST_IDLE && cpu_req_i && cpu_cmd_i.space == sbm_pkg::SP_NONE) begin
            cpu_err_o <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Bus drive
   // -----------------------------------------------------------------
   // Request and commands exist only while a remote cycle is live, so a timeout drops both.
   assign bus_owned   = (state == ST_CMD) && !timed_out;
   assign breq_n_o    = !is_remote(state);
   // Priority is held back while arbitrating so no lower master claims the free bus at the same time.
   assign bpro_n_o    = bprn_n_i || (state == ST_REQ);
   assign busy_n_o    = 1'b0;
   assign busy_n_oe_o = bus_owned;
   // No slave decoder exists, so the bus is only ever driven as master and on-board memory stays private.
   assign bus_oe_o    = bus_owned;
   assign local_sel_o = (state == ST_LOCAL);

   // Command lines are active high in the struct; pad drivers invert them.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         bus_o <= '0;
      end else begin
         bus_o.adr  <= cpu_cmd_i.addr[sbm_pkg::ADDR_W-1:0];
         bus_o.dat  <= cpu_cmd_i.wdata;
         // Address and write data follow the processor every cycle; only the strobes qualify them.
         {bus_o.mrd, bus_o.mwr, bus_o.iord, bus_o.iowr} <= strobes(bus_owned, cpu_cmd_i.space, cpu_cmd_i.write);
      end
   end

   // -----------------------------------------------------------------
   // Bus services
   // -----------------------------------------------------------------
   // Clocks toggle at half the master rate; held high (inactive) when the option is off.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         bclk_n_o <= 1'b1;
         cclk_n_o <= 1'b1;
      end else begin
         bclk_n_o <= clk_master_i ? !bclk_n_o : 1'b1;
         cclk_n_o <= clk_master_i ? !cclk_n_o : 1'b1;
      end
   end
   // Without the clock option the board cannot see the bus clock phase, so every cycle qualifies.
   assign bclk_en = !bclk_n_o || !clk_master_i;

   // Init is stretched so even a one-cycle program write produces a usable pulse.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         init_cnt <= 8'(sbm_pkg::INIT_HOLD_CYC);
      end else if (init_prog_i || power_fail_i) begin
         init_cnt <= 8'(sbm_pkg::INIT_HOLD_CYC);
      end else if (init_cnt != 8'h00) begin
         init_cnt <= init_cnt - 8'h01;
      end
   end
   assign init_n_o    = 1'b0;
   assign init_n_oe_o = clk_master_i && (init_cnt != 8'h00);
endmodule

// >>> sbm_master_props.sv
// Checker properties for the system bus master, bound to its ports.
`timescale 1ns/100ps
module sbm_master_props (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cpu_ack_o,
   input wire logic cpu_err_o,
   input wire logic local_sel_o,
   input wire logic local_ack_i,
   input wire logic clk_master_i,
   input wire logic init_prog_i,
   input wire logic bprn_n_i,
   input wire logic bpro_n_o,
   input wire logic breq_n_o,
   input wire logic busy_n_i,
   input wire logic busy_n_o,
   input wire logic busy_n_oe_o,
   input wire logic bus_oe_o,
   input wire logic bclk_n_o,
   input wire logic init_n_oe_o
);
   logic [7:0] wait_cnt;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Cycles with the request low; it saturates so a hang cannot wrap back to a legal count.
   always_ff @(posedge mclk_i) begin
      wait_cnt <= (rst_i || breq_n_o) ? 8'h00 : wait_cnt + {7'h00, wait_cnt != 8'hff};
   end
   a_local_quiet: assert property (local_sel_o |-> breq_n_o && !bus_oe_o) else $error("local cycle used bus");
   a_local_ack: assert property (local_sel_o && local_ack_i |=> cpu_ack_o) else $error("local ack lost");
   a_hang_bound: assert property (wait_cnt < 8'h9b) else $error("hung cycle not aborted");
   a_err_release: assert property (cpu_err_o |=> breq_n_o && !bus_oe_o) else $error("bus kept after abort");
   a_grant_prio: assert property ($rose(bus_oe_o) |-> !$past(bprn_n_i) && $past(busy_n_i))
      else $error("bus taken without priority");
   a_prio_pass: assert property (breq_n_o && !bus_oe_o |-> bpro_n_o == bprn_n_i) else $error("priority not passed");
   a_init_prog: assert property (init_prog_i && clk_master_i |-> ##[0:2] init_n_oe_o) else $error("program init ignored");
   a_master_only: assert property (bus_oe_o |-> !breq_n_o) else $error("bus driven without request");
   a_busy_own: assert property (bus_oe_o |-> busy_n_oe_o && !busy_n_o) else $error("busy not held while owning");
   a_clk_toggle: assert property (clk_master_i && $past(clk_master_i) && !$past(rst_i) |-> bclk_n_o != $past(bclk_n_o))
      else $error("bus clock stalled");
   c_abort: cover property (cpu_err_o);
   c_grant: cover property ($rose(bus_oe_o));
   c_local: cover property (local_sel_o && local_ack_i);
endmodule

bind sbm_master sbm_master_props chk (
   .mclk_i      (mclk_i),
   .rst_i       (rst_i),
   .cpu_ack_o   (cpu_ack_o),
   .cpu_err_o   (cpu_err_o),
   .local_sel_o (local_sel_o),
   .local_ack_i (local_ack_i),
   .clk_master_i(clk_master_i),
   .init_prog_i (init_prog_i),
   .bprn_n_i    (bprn_n_i),
   .bpro_n_o    (bpro_n_o),
   .breq_n_o    (breq_n_o),
   .busy_n_i    (busy_n_i),
   .busy_n_o    (busy_n_o),
   .busy_n_oe_o (busy_n_oe_o),
   .bus_oe_o    (bus_oe_o),
   .bclk_n_o    (bclk_n_o),
   .init_n_oe_o (init_n_oe_o)
);

// >>> sbm_partner.sv
// Model of a remote slave and a competing higher priority master on the system bus.
`timescale 1ns/100ps
module sbm_partner (
   input  wire logic               mclk_i,
   input  wire sbm_pkg::sbus_cmd_s bus_i,
   input  wire logic               oe_i,
   input  wire logic               hog_i,
   input  wire logic               mute_i,
   input  wire logic [3:0]         lag_i,
   output logic                    xack_n_o,
   output logic [15:0]             dat_o,
   output logic                    bprn_n_o,
   output logic                    busy_n_o
);
   logic [3:0]  age;
   logic [15:0] rd;
   logic        cmd;
   // A hogging master of higher rank withholds priority and keeps the bus busy.
   assign bprn_n_o = hog_i;
   assign busy_n_o = !hog_i;
   // Data encodes address and space; a released line shows the inverse, never a stale value.
   assign cmd = oe_i && |{bus_i.mrd, bus_i.mwr, bus_i.iord, bus_i.iowr};
   assign rd = bus_i.adr[15:0] ^ (bus_i.iord ? 16'h0f0f : 16'ha5c3);
   assign dat_o = xack_n_o ? ~rd : rd;
   // One acknowledge pulse after lag_i + 1 command cycles; a muted slave never answers.
   always_ff @(posedge mclk_i) begin
      age <= (cmd && xack_n_o) ? age + 4'h1 : 4'h0;
      xack_n_o <= !(cmd && xack_n_o && age >= lag_i && !mute_i);
   end
endmodule

// >>> system_bus_master_interface_bench.sv
// Self-checking bench for the system bus master interface.
`timescale 1ns/100ps
module system_bus_master_interface_bench;
   typedef struct packed {
      sbm_pkg::space_e space;
      logic            write;
      logic [23:0]     addr;
      logic            err;
      logic [15:0]     data;
   } row_s;
   logic               mclk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cpu_req_i = 1'b0;
   sbm_pkg::cpu_req_s  cpu_cmd_i = '0;
   logic               local_ack_i = 1'b0;
   logic [15:0]        local_rdata_i = 16'hbeef;
   logic               clk_master_i = 1'b1;
   logic               init_prog_i = 1'b0;
   logic               power_fail_i = 1'b0;
   logic               hog = 1'b0;
   logic               mute = 1'b0;
   logic [3:0]         lag = 4'h1;
   logic               bprn_n_i, busy_n_i, xack_n_i, far_busy_n, b;
   logic [15:0]        bus_dat_i, cpu_rdata_o;
   logic               cpu_ack_o, cpu_err_o, local_sel_o, bpro_n_o, breq_n_o, busy_n_o, busy_n_oe_o;
   logic               bus_oe_o, bclk_n_o, cclk_n_o, init_n_o, init_n_oe_o;
   sbm_pkg::sbus_cmd_s bus_o;
   int                 error_cnt = 0;
   int                 tests_run = 0;
   int                 n;
   row_s rows [6] = '{
      '{sbm_pkg::SP_LOCAL, 1'b0, 24'h000100, 1'b0, 16'hbeef},
      '{sbm_pkg::SP_MEM, 1'b0, 24'h0f1234, 1'b0, 16'hb7f7},
      '{sbm_pkg::SP_MEM, 1'b0, 24'h0fffff, 1'b0, 16'h5a3c},
      '{sbm_pkg::SP_IO, 1'b0, 24'h0abcde, 1'b0, 16'hb3d1},
      '{sbm_pkg::SP_IO, 1'b1, 24'h012345, 1'b0, 16'h0000},
      '{sbm_pkg::SP_NONE, 1'b0, 24'h000000, 1'b1, 16'h0000}};
   // Busy is open drain: low if the far master or this board pulls it.
   assign busy_n_i = far_busy_n && !(busy_n_oe_o && !busy_n_o);
   sbm_master uut (
      .mclk_i       (mclk_i),
      .rst_i        (rst_i),
      .cpu_req_i    (cpu_req_i),
      .cpu_cmd_i    (cpu_cmd_i),
      .cpu_ack_o    (cpu_ack_o),
      .cpu_err_o    (cpu_err_o),
      .cpu_rdata_o  (cpu_rdata_o),
      .local_sel_o  (local_sel_o),
      .local_ack_i  (local_ack_i),
      .local_rdata_i(local_rdata_i),
      .clk_master_i (clk_master_i),
      .init_prog_i  (init_prog_i),
      .power_fail_i (power_fail_i),
      .bprn_n_i     (bprn_n_i),
      .bpro_n_o     (bpro_n_o),
      .breq_n_o     (breq_n_o),
      .busy_n_i     (busy_n_i),
      .busy_n_o     (busy_n_o),
      .busy_n_oe_o  (busy_n_oe_o),
      .bus_o        (bus_o),
      .bus_oe_o     (bus_oe_o),
      .bus_dat_i    (bus_dat_i),
      .xack_n_i     (xack_n_i),
      .bclk_n_o     (bclk_n_o),
      .cclk_n_o     (cclk_n_o),
      .init_n_o     (init_n_o),
      .init_n_oe_o  (init_n_oe_o)
   );
   sbm_partner peer (.mclk_i(mclk_i), .bus_i(bus_o), .oe_i(bus_oe_o), .hog_i(hog), .mute_i(mute), .lag_i(lag),
      .xack_n_o(xack_n_i), .dat_o(bus_dat_i), .bprn_n_o(bprn_n_i), .busy_n_o(far_busy_n));
   // Clock and a one-cycle local memory acknowledge per selection.
   always #50 mclk_i = ~mclk_i;
   always @(negedge mclk_i) local_ack_i <= local_sel_o && !local_ack_i;
   task automatic chk1(input string what, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk20(input string what, input logic [19:0] e, input logic [19:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   // Request held until answered, then dropped for one cycle as the handshake demands.
   // Strobes still stand at the acknowledge, and an aborted cycle must already have dropped them.
   task automatic run_cycle(input row_s r);
      logic [3:0] cmd;
      cpu_cmd_i = '{r.addr, r.space, r.write, r.addr[15:0]};
      cpu_req_i = 1'b1;
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (cpu_ack_o !== 1'b1 && cpu_err_o !== 1'b1 && n < 300);
      chk1("error", r.err, cpu_err_o);
      if (!r.write && !r.err) chk16("rdata", r.data, cpu_rdata_o);
      cmd = {r.space == sbm_pkg::SP_MEM && !r.write, r.space == sbm_pkg::SP_MEM && r.write,
             r.space == sbm_pkg::SP_IO && !r.write, r.space == sbm_pkg::SP_IO && r.write};
      if (r.err) cmd = 4'h0;
      chk16("strobes", {12'h000, cmd}, {12'h000, bus_o.mrd, bus_o.mwr, bus_o.iord, bus_o.iowr});
      if (cmd != 4'h0) chk20("address", r.addr[19:0], bus_o.adr);
      if (cmd != 4'h0 && r.write) chk16("wdata", r.addr[15:0], bus_o.dat);
      cpu_req_i = 1'b0;
      @(negedge mclk_i);
   endtask
   task automatic print_verdict;
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog: the sequence needs well under a thousand cycles.
   initial begin
      #(5000 * 100);
      error_cnt++;
      print_verdict;
   end
   // Main sequence, all stimulus applied at falling edges.
   initial begin
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      @(negedge mclk_i);
      chk1("breq idle", 1'b1, breq_n_o);
      chk1("init strap", 1'b1, init_n_oe_o);
      chk1("priority out", 1'b0, bpro_n_o);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         run_cycle(rows[i]);
         $display("row %0d done", i);
      end
      mute = 1'b1;
      run_cycle('{sbm_pkg::SP_MEM, 1'b0, 24'h000010, 1'b1, 16'h0000});
      chk1("abort time", 1'b1, n >= 148 && n <= 155);
      mute = 1'b0;
      $display("timeout test done");
      hog = 1'b1;
      lag = 4'hf;
      fork
         run_cycle(rows[1]);
         begin
            repeat (20) @(negedge mclk_i);
            chk1("yield", 1'b0, bus_oe_o);
            chk1("request", 1'b0, breq_n_o);
            hog = 1'b0;
         end
      join
      $display("arbitration test done");
      init_prog_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      chk1("init", 1'b1, init_n_oe_o);
      init_prog_i = 1'b0;
      b = bclk_n_o;
      @(negedge mclk_i);
      chk1("bus clock", ~b, bclk_n_o);
      repeat (20) @(negedge mclk_i);
      chk1("init end", 1'b0, init_n_oe_o);
      power_fail_i = 1'b1;
      @(negedge mclk_i);
      chk1("power fail init", 1'b1, init_n_oe_o);
      power_fail_i = 1'b0;
      clk_master_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      chk1("clock off", 1'b1, bclk_n_o & cclk_n_o);
      chk1("init strap off", 1'b0, init_n_oe_o);
      $display("service test done");
      print_verdict;
   end
endmodule
